// ---- cgen_defines.svh ----
// register map, field positions and reset values of the complementary generator
`ifndef CGEN_DEFINES_SVH
`define CGEN_DEFINES_SVH
`define OFF_CTRL0 8'h00
`define OFF_CTRL1 8'h04
`define OFF_RSRC 8'h08
`define OFF_RSENSE 8'h0C
`define OFF_FSRC 8'h10
`define OFF_FSENSE 8'h14
`define OFF_SDSRC 8'h18
`define OFF_SDCTRL 8'h1C
`define OFF_OVR 8'h20
`define OFF_STEER 8'h24
`define OFF_RDB 8'h28
`define OFF_FDB 8'h2C
`define OFF_RBK 8'h30
`define OFF_FBK 8'h34
`define OFF_RPH 8'h38
`define OFF_FPH 8'h3C
`define OFF_STATUS 8'h40
`define EN_BIT 7
`define CS_HI 4
`define CS_LO 3
`define MD_HI 2
`define MD_LO 0
`define RDBS_BIT 7
`define FDBS_BIT 6
`define POL_HI 3
`define POL_LO 0
`define RESTART_BIT 7
`define SDCLR_BIT 0
`define SDATA_HI 7
`define SDATA_LO 4
`define SEN_HI 3
`define SEN_LO 0
`define BYTE_W 8
`define TIMER_W 6
`define NSRC 8
`define NOUT 4
`define OVR_W 2
`define REG_RST 8'h00
`define INSTR_LAST 2'h3
`define RD_PAD 24'h000000
`endif

// ---- cgen_pkg.sv ----
// types shared by the complementary generator modules
`include "cgen_defines.svh"
package cgen_pkg;
	typedef enum logic [2:0] {
		MD_STEER = 3'h0,
		MD_SYNC_STEER = 3'h1,
		MD_FB_FWD = 3'h2,
		MD_FB_REV = 3'h3,
		MD_HALF = 3'h4,
		MD_PUSH = 3'h5
	} mode_t;
	typedef enum logic [1:0] {ST_OFF = 2'h0, ST_RPH = 2'h1, ST_ON = 2'h3, ST_FPH = 2'h2} phase_t;
	typedef enum logic [1:0] {OVR_INACT = 2'h0, OVR_HIZ = 2'h1, OVR_LOW = 2'h2, OVR_HIGH = 2'h3} ovr_t;
	typedef enum logic [1:0] {CS_OSC = 2'h0, CS_INSTR = 2'h1, CS_SYS = 2'h2} clk_sel_t;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [`BYTE_W-1:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} wb_rsp_t;
	typedef struct packed {
		logic [`NOUT-1:0] out;
		logic [`NOUT-1:0] oe;
	} drive_t;
	typedef struct packed {
		logic en;
		logic [1:0] cs;
		logic [2:0] md;
		logic rdbs;
		logic fdbs;
		logic [`NOUT-1:0] pol;
		logic [`NSRC-1:0] rsrc;
		logic [`NSRC-1:0] rsense;
		logic [`NSRC-1:0] fsrc;
		logic [`NSRC-1:0] fsense;
		logic [`NSRC-1:0] sdsrc;
		logic restart;
		logic [`BYTE_W-1:0] ovr;
		logic [`NOUT-1:0] sdata;
		logic [`NOUT-1:0] sen;
		logic [`TIMER_W-1:0] rdb;
		logic [`TIMER_W-1:0] fdb;
		logic [`TIMER_W-1:0] rbk;
		logic [`TIMER_W-1:0] fbk;
		logic [`TIMER_W-1:0] rph;
		logic [`TIMER_W-1:0] fph;
	} regs_t;
	typedef struct packed {
		regs_t regs;
		phase_t phase;
		logic ack;
		logic [`BYTE_W-1:0] rdat;
		logic [1:0] div;
		logic osc1;
		logic osc2;
		logic osc_prev;
		logic shut;
		logic pair;
		logic [`NOUT-1:0] str_sync;
		logic last_dir;
		logic dchg;
		drive_t drv;
	} top_state_t;
endpackage : cgen_pkg

// ---- event_detect.sv ----
// synchronised, selectable edge or level detection of a group of event sources
`timescale 1ns/1ps
`default_nettype none
`include "cgen_defines.svh"
module event_detect #(
	parameter int N = `NSRC,
	parameter bit FALL = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [N-1:0] src,
	input wire logic [N-1:0] sel,
	input wire logic [N-1:0] sense,
	output logic evt
);
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] prev;
	} ed_state_t;
	ed_state_t st;
	ed_state_t next_st;
	logic [N-1:0] lvl;
	logic [N-1:0] edg;
	always_comb begin
		next_st.s1 = src;
		next_st.s2 = st.s1;
		next_st.prev = st.s2;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	// falling sources are active on the high-to-low side
	assign lvl = FALL ? ~st.s2 : st.s2;
	assign edg = FALL ? (st.prev & ~st.s2) : (st.s2 & ~st.prev);
	assign evt = |(sel & ((sense & edg) | (~sense & lvl)));
endmodule : event_detect
`default_nettype wire

// ---- delay_timer.sv ----
// down-counter for phase delay, blanking and dead-band times
`timescale 1ns/1ps
`default_nettype none
`include "cgen_defines.svh"
module delay_timer #(
	parameter int W = `TIMER_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [W-1:0] load,
	input wire logic tick,
	output logic busy
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} dt_state_t;
	dt_state_t st;
	dt_state_t next_st;
	always_comb begin
		next_st = st;
		if (start) begin
			next_st.cnt = load;
		end else if (tick && st.cnt != '0) begin
			next_st.cnt = st.cnt - 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	// registered only, so starts never loop back combinationally
	assign busy = (st.cnt != '0);
endmodule : delay_timer
`default_nettype wire

// ---- complementary_gen.sv ----
// complementary output generator with wishbone register slave
// Function
// - rising event sets the period, rising-to-falling interval sets the duty
// - events come from shared or separate sources, synchronous or not
// - phase, blanking and dead-band run on module clock; dead-band may bypass it
// - four outputs a to d, waveform chosen by three-bit mode field
// - mode 000 steers one pwm to any outputs, next cycle after write
// - mode 001 steering change applies at first rising event after write
// - synchronous steered mode applies static data immediately
// - full-bridge: two outputs active, one modulated, one held on
// - full-bridge direction change delays modulated output by dead-band
// - mode 010 modulates output d and holds output a on
// - mode 011 modulates output b and holds output c on
// - mode 100 makes a complementary pair matching the input pwm
// - half-bridge delays each turn-on after the other turn-off
// - half-bridge primary on a and/or c, complement on b and/or d
// - push-pull alternates output pairs on every period
// - push-pull: c follows a, d follows b, rising to falling
// - optional blanking of falling after rise, rising after fall
// - optional phase delay after each event, rise and fall set apart
// - selected shutdown sources end active drive; auto-restart option
// - shutdown forces each output (in steering modes each steered one) high, low, inactive or high-z
// - per-source edge or level sensing of rising and falling sources, per-output polarity
// - set sense bit means edge, clear means level; sources ored
// - disabled or just enabled: primary inactive, complementary active
// - module clock chosen from fast oscillator, instruction or system clock
// - falling event clears primary, starts blanking and phase delay, then dead-band, then complement
`timescale 1ns/1ps
`default_nettype none
`include "cgen_defines.svh"
module complementary_gen (
	input wire logic clk,
	input wire logic rst,
	input wire cgen_pkg::wb_req_t wb_req,
	output var cgen_pkg::wb_rsp_t wb_rsp,
	input wire logic [`NSRC-1:0] rise_src,
	input wire logic [`NSRC-1:0] fall_src,
	input wire logic [`NSRC-1:0] sd_src,
	input wire logic osc_tick,
	output var cgen_pkg::drive_t drive
);
	localparam int T_RPH = 0;
	localparam int T_FPH = 1;
	localparam int T_RBK = 2;
	localparam int T_FBK = 3;
	localparam int T_RDB = 4;
	localparam int T_FDB = 5;
	localparam int NT = 6;
	cgen_pkg::top_state_t st;
	cgen_pkg::top_state_t next_st;
	logic req;
	logic wr;
	logic [`BYTE_W-1:0] wd;
	logic r_evt;
	logic f_evt;
	logic sd_evt;
	logic mtick;
	logic sw_clr;
	logic rise_trig;
	logic fall_trig;
	logic fb;
	logic dir;
	logic pwm;
	logic prim;
	logic comp;
	logic modul;
	logic [`NOUT-1:0] steer_en;
	logic [`NOUT-1:0] lo;
	logic [`NOUT-1:0] apply;
	logic [NT-1:0] t_start;
	logic [NT-1:0] t_busy;
	logic [NT-1:0] t_tick;
	logic [`TIMER_W-1:0] t_load [NT];
	assign req = wb_req.cyc & wb_req.stb & ~st.ack;
	// write lands on the ack edge, where the master takes its answer
	assign wr = wb_req.cyc & wb_req.stb & st.ack & wb_req.we & wb_req.sel[0];
	assign wd = wb_req.dat[`BYTE_W-1:0];
	assign wb_rsp.ack = st.ack;
	assign wb_rsp.dat = {`RD_PAD, st.rdat};
	assign drive = st.drv;

	// sources are synchronised inside, so async inputs are safe
	event_detect #(.N(`NSRC), .FALL(1'b0)) u_rise (
		.clk(clk),
		.rst(rst),
		.src(rise_src),
		.sel(st.regs.rsrc),
		.sense(st.regs.rsense),
		.evt(r_evt)
	);
	event_detect #(.N(`NSRC), .FALL(1'b1)) u_fall (
		.clk(clk),
		.rst(rst),
		.src(fall_src),
		.sel(st.regs.fsrc),
		.sense(st.regs.fsense),
		.evt(f_evt)
	);
	// shutdown sources are level sensed only
	event_detect #(.N(`NSRC), .FALL(1'b0)) u_shut (
		.clk(clk),
		.rst(rst),
		.src(sd_src),
		.sel(st.regs.sdsrc),
		.sense({`NSRC{1'b0}}),
		.evt(sd_evt)
	);

	assign t_load[T_RPH] = st.regs.rph;
	assign t_load[T_FPH] = st.regs.fph;
	assign t_load[T_RBK] = st.regs.rbk;
	assign t_load[T_FBK] = st.regs.fbk;
	assign t_load[T_RDB] = st.regs.rdb;
	assign t_load[T_FDB] = st.regs.fdb;

	for (genvar g = 0; g < NT; g++) begin : g_tmr
		delay_timer #(.W(`TIMER_W)) u_tmr (
			.clk(clk),
			.rst(rst),
			.start(t_start[g]),
			.load(t_load[g]),
			.tick(t_tick[g]),
			.busy(t_busy[g])
		);
	end

	always_comb begin
		next_st = st;
		t_start = '0;
		sw_clr = 1'b0;
		lo = '0;
		apply = {`NOUT{1'b1}};
		// module clock as a tick; the fast oscillator arrives as a synced toggle
		case (st.regs.cs)
			cgen_pkg::CS_OSC: mtick = st.osc2 & ~st.osc_prev;
			cgen_pkg::CS_INSTR: mtick = (st.div == `INSTR_LAST);
			default: mtick = 1'b1;
		endcase
		// delay-chain option counts at system rate, independent of the selection
		t_tick = {NT{mtick}};
		t_tick[T_RDB] = st.regs.rdbs | mtick;
		t_tick[T_FDB] = st.regs.fdbs | mtick;
		next_st.osc1 = osc_tick;
		next_st.osc2 = st.osc1;
		next_st.osc_prev = st.osc2;
		next_st.div = st.div + 1'b1;

		next_st.ack = req;
		if (req) begin
			case (wb_req.adr)
				`OFF_CTRL0: next_st.rdat = {st.regs.en, 1'b0, 1'b0, st.regs.cs, st.regs.md};
				`OFF_CTRL1: next_st.rdat = {st.regs.rdbs, st.regs.fdbs, 1'b0, 1'b0, st.regs.pol};
				`OFF_RSRC: next_st.rdat = st.regs.rsrc;
				`OFF_RSENSE: next_st.rdat = st.regs.rsense;
				`OFF_FSRC: next_st.rdat = st.regs.fsrc;
				`OFF_FSENSE: next_st.rdat = st.regs.fsense;
				`OFF_SDSRC: next_st.rdat = st.regs.sdsrc;
				`OFF_SDCTRL: next_st.rdat = {st.regs.restart, 7'h00};
				`OFF_OVR: next_st.rdat = st.regs.ovr;
				`OFF_STEER: next_st.rdat = {st.regs.sdata, st.regs.sen};
				`OFF_RDB: next_st.rdat = 8'(st.regs.rdb);
				`OFF_FDB: next_st.rdat = 8'(st.regs.fdb);
				`OFF_RBK: next_st.rdat = 8'(st.regs.rbk);
				`OFF_FBK: next_st.rdat = 8'(st.regs.fbk);
				`OFF_RPH: next_st.rdat = 8'(st.regs.rph);
				`OFF_FPH: next_st.rdat = 8'(st.regs.fph);
				`OFF_STATUS: next_st.rdat = {st.shut, 1'b0, st.phase, st.drv.out};
				default: next_st.rdat = `REG_RST;
			endcase
		end
		if (wr) begin
			case (wb_req.adr)
				`OFF_CTRL0: begin
					next_st.regs.en = wd[`EN_BIT];
					next_st.regs.cs = wd[`CS_HI:`CS_LO];
					next_st.regs.md = wd[`MD_HI:`MD_LO];
				end
				`OFF_CTRL1: begin
					next_st.regs.rdbs = wd[`RDBS_BIT];
					next_st.regs.fdbs = wd[`FDBS_BIT];
					next_st.regs.pol = wd[`POL_HI:`POL_LO];
				end
				`OFF_RSRC: next_st.regs.rsrc = wd;
				`OFF_RSENSE: next_st.regs.rsense = wd;
				`OFF_FSRC: next_st.regs.fsrc = wd;
				`OFF_FSENSE: next_st.regs.fsense = wd;
				`OFF_SDSRC: next_st.regs.sdsrc = wd;
				`OFF_SDCTRL: begin
					next_st.regs.restart = wd[`RESTART_BIT];
					sw_clr = wd[`SDCLR_BIT];
				end
				`OFF_OVR: next_st.regs.ovr = wd;
				`OFF_STEER: begin
					next_st.regs.sdata = wd[`SDATA_HI:`SDATA_LO];
					next_st.regs.sen = wd[`SEN_HI:`SEN_LO];
				end
				`OFF_RDB: next_st.regs.rdb = wd[`TIMER_W-1:0];
				`OFF_FDB: next_st.regs.fdb = wd[`TIMER_W-1:0];
				`OFF_RBK: next_st.regs.rbk = wd[`TIMER_W-1:0];
				`OFF_FBK: next_st.regs.fbk = wd[`TIMER_W-1:0];
				`OFF_RPH: next_st.regs.rph = wd[`TIMER_W-1:0];
				`OFF_FPH: next_st.regs.fph = wd[`TIMER_W-1:0];
				default: ;
			endcase
		end

		// blanking masks the opposite event
		rise_trig = r_evt & ~t_busy[T_RBK] & st.regs.en & ~st.shut;
		fall_trig = f_evt & ~t_busy[T_FBK] & st.regs.en;
		// set wins over any clear; restart needs sources gone and a rising event
		if (sd_evt) begin
			next_st.shut = 1'b1;
		end else if ((st.regs.restart & r_evt) | sw_clr) begin
			next_st.shut = 1'b0;
		end

		if (!st.regs.en || st.shut) begin
			next_st.phase = cgen_pkg::ST_OFF;
		end else begin
			unique case (st.phase)
				cgen_pkg::ST_OFF: begin
					if (rise_trig) begin
						next_st.phase = cgen_pkg::ST_RPH;
						t_start[T_RPH] = 1'b1;
					end
				end
				cgen_pkg::ST_RPH: begin
					if (fall_trig) begin
						next_st.phase = cgen_pkg::ST_FPH;
						t_start[T_FPH] = 1'b1;
						t_start[T_RBK] = 1'b1;
					end else if (!t_busy[T_RPH]) begin
						next_st.phase = cgen_pkg::ST_ON;
						t_start[T_RDB] = 1'b1;
						t_start[T_FBK] = 1'b1;
						next_st.pair = ~st.pair;
						next_st.str_sync = st.regs.sen;
					end
				end
				cgen_pkg::ST_ON: begin
					if (fall_trig) begin
						next_st.phase = cgen_pkg::ST_FPH;
						t_start[T_FPH] = 1'b1;
						t_start[T_RBK] = 1'b1;
					end
				end
				cgen_pkg::ST_FPH: begin
					if (!t_busy[T_FPH]) begin
						next_st.phase = cgen_pkg::ST_OFF;
						t_start[T_FDB] = 1'b1;
					end
				end
			endcase
		end

		// direction change in full-bridge restarts a dead-band on the new side
		fb = (st.regs.md == cgen_pkg::MD_FB_FWD) || (st.regs.md == cgen_pkg::MD_FB_REV);
		dir = st.regs.md[0];
		if (fb) begin
			next_st.last_dir = dir;
			if (dir != st.last_dir) begin
				next_st.dchg = 1'b1;
				if (dir) begin
					t_start[T_FDB] = 1'b1;
				end else begin
					t_start[T_RDB] = 1'b1;
				end
			end else if (st.dchg && !t_busy[T_RDB] && !t_busy[T_FDB]) begin
				next_st.dchg = 1'b0;
			end
		end else begin
			next_st.dchg = 1'b0;
		end

		pwm = (st.phase == cgen_pkg::ST_ON);
		prim = pwm & ~t_busy[T_RDB];
		comp = ((st.phase == cgen_pkg::ST_OFF) || (st.phase == cgen_pkg::ST_RPH)) & ~t_busy[T_FDB];
		modul = pwm & ~st.dchg;
		// synchronous mode latches the enables; static data bypasses the latch
		steer_en = (st.regs.md == cgen_pkg::MD_STEER) ? st.regs.sen : st.str_sync;
		// bit order is {d, c, b, a}
		case (st.regs.md)
			cgen_pkg::MD_STEER, cgen_pkg::MD_SYNC_STEER: begin
				for (int i = 0; i < `NOUT; i++) begin
					lo[i] = steer_en[i] ? pwm : st.regs.sdata[i];
				end
				apply = steer_en;
			end
			cgen_pkg::MD_FB_FWD: lo = {modul, 1'b0, 1'b0, st.regs.en};
			cgen_pkg::MD_FB_REV: lo = {1'b0, st.regs.en, modul, 1'b0};
			cgen_pkg::MD_HALF: lo = {comp, prim, comp, prim} & st.regs.sen;
			cgen_pkg::MD_PUSH: lo = {pwm & st.pair, pwm & ~st.pair, pwm & st.pair, pwm & ~st.pair};
			default: lo = '0;
		endcase
		for (int i = 0; i < `NOUT; i++) begin
			next_st.drv.oe[i] = 1'b1;
			if (st.shut && apply[i]) begin
				unique case (cgen_pkg::ovr_t'(st.regs.ovr[`OVR_W*i +: `OVR_W]))
					cgen_pkg::OVR_INACT: next_st.drv.out[i] = st.regs.pol[i];
					cgen_pkg::OVR_HIZ: begin
						next_st.drv.out[i] = 1'b0;
						next_st.drv.oe[i] = 1'b0;
					end
					cgen_pkg::OVR_LOW: next_st.drv.out[i] = 1'b0;
					cgen_pkg::OVR_HIGH: next_st.drv.out[i] = 1'b1;
				endcase
			end else begin
				// polarity last, so every mode shares one inversion point
				next_st.drv.out[i] = lo[i] ^ st.regs.pol[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_rise_start: assert property (
		(st.phase == cgen_pkg::ST_OFF && rise_trig && st.regs.en && !st.shut) |=> st.phase == cgen_pkg::ST_RPH
	) else $error("rising event did not start a period");
	chk_sync_hold: assert property (
		(st.regs.md == cgen_pkg::MD_SYNC_STEER && next_st.phase != cgen_pkg::ST_ON) |=> $stable(st.str_sync)
	) else $error("sync steering changed without a rising event");
	chk_fb_dirchange: assert property (
		(fb && dir != st.last_dir) |=> st.dchg
	) else $error("direction change did not hold the modulated output");
	chk_fwd_a_on: assert property (
		(st.regs.md == cgen_pkg::MD_FB_FWD && st.regs.en && !st.shut)
		|=> drive.out[0] == !$past(st.regs.pol[0]) && !drive.out[1] == !$past(st.regs.pol[1])
	) else $error("forward bridge output a not held on");
	chk_rev_c_on: assert property (
		(st.regs.md == cgen_pkg::MD_FB_REV && st.regs.en && !st.shut)
		|=> drive.out[2] == !$past(st.regs.pol[2]) && drive.out[0] == $past(st.regs.pol[0])
	) else $error("reverse bridge output c not held on");
	chk_hb_deadband: assert property (
		(st.regs.md == cgen_pkg::MD_HALF && !st.shut && t_busy[T_RDB] && st.regs.sen[0])
		|=> drive.out[0] == $past(st.regs.pol[0])
	) else $error("primary went active inside dead-band");
	chk_pair_toggle: assert property (
		(st.phase == cgen_pkg::ST_RPH && next_st.phase == cgen_pkg::ST_ON) |=> st.pair != $past(st.pair)
	) else $error("push-pull pair did not alternate");
	chk_push_same: assert property (
		(st.regs.md == cgen_pkg::MD_PUSH && !st.shut && st.regs.pol[0] == st.regs.pol[2])
		|=> drive.out[0] == drive.out[2]
	) else $error("push-pull outputs a and c differ");
	chk_fall_blank: assert property (
		(st.phase == cgen_pkg::ST_ON && t_busy[T_FBK] && st.regs.en && !st.shut) |=> st.phase == cgen_pkg::ST_ON
	) else $error("falling event not blanked");
	chk_shut_off: assert property (
		sd_evt |=> st.shut ##1 st.phase == cgen_pkg::ST_OFF
	) else $error("shutdown did not end the drive");
	chk_disabled_idle: assert property (
		!st.regs.en |=> st.phase == cgen_pkg::ST_OFF
	) else $error("disabled module left the off phase");
	cov_push: cover property (st.regs.md == cgen_pkg::MD_PUSH && st.pair ##1 !st.pair);
	cov_hb_cycle: cover property (st.regs.md == cgen_pkg::MD_HALF && st.phase == cgen_pkg::ST_FPH);
	cov_dirchange: cover property (st.dchg && st.phase == cgen_pkg::ST_ON);
	cov_shutdown: cover property (st.shut ##1 !st.shut);
endmodule : complementary_gen
`default_nettype wire

// ---- bridge_switch_model.sv ----
// behavioural model of the external half/full-bridge power switches
`timescale 1ns/1ps
`default_nettype none
module bridge_switch_model (
	input wire logic clk,
	input wire logic rst,
	input wire cgen_pkg::drive_t drive,
	input wire logic [3:0] act_low,
	output logic [15:0] overlaps
);
	logic [3:0] on;
	// a switch conducts only when its driver is enabled and at its active level
	assign on = (drive.out ^ act_low) & drive.oe;
	// legs are a/b and c/d; both switches of one leg on means shoot-through
	always_ff @(posedge clk) begin
		if (rst) begin
			overlaps <= 16'h0000;
		end else if ((on[0] & on[1]) | (on[2] & on[3])) begin
			overlaps <= overlaps + 16'h0001;
		end
	end
endmodule : bridge_switch_model
`default_nettype wire

// ---- tb_top.sv ----
// self-checking testbench of the complementary generator
`timescale 1ns/1ps
`default_nettype none
`include "cgen_defines.svh"
module tb_top;
	logic clk;
	logic rst;
	logic pwm;
	logic sd;
	logic osc;
	logic [3:0] pol;
	cgen_pkg::wb_req_t req;
	cgen_pkg::wb_rsp_t rsp;
	cgen_pkg::drive_t drive;
	logic [15:0] overlaps;
	int mismatches;
	int checked;
	logic [31:0] d;
	logic [3:0] h;
	logic [3:0] l;
	logic [3:0] h2;
	int g;
	logic [15:0] ov0;

	complementary_gen dut (.clk(clk), .rst(rst), .wb_req(req), .wb_rsp(rsp), .rise_src({7'h00, pwm}),
		.fall_src({7'h00, pwm}), .sd_src({7'h00, sd}), .osc_tick(osc), .drive(drive));
	bridge_switch_model sw (.clk(clk), .rst(rst), .drive(drive), .act_low(pol), .overlaps(overlaps));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// slow square wave standing in for the fast oscillator
	always @(posedge clk) osc <= rst ? 1'b0 : ~osc;

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one classic cycle; ack and data taken at the rising edge, request dropped at that same edge
	task bus(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] rd);
		@(posedge clk);
		req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: {24'h000000, wd}};
		do begin
			@(posedge clk);
		end while (rsp.ack !== 1'b1);
		rd = rsp.dat;
		req <= '0;
	endtask : bus

	task wr(input logic [7:0] a, input logic [7:0] wd);
		logic [31:0] x;
		bus(1'b1, a, wd, x);
	endtask : wr

	task level(input logic v, input int n, output logic [3:0] o);
		@(posedge clk);
		pwm <= v;
		repeat (n) @(negedge clk);
		o = drive.out;
	endtask : level

	task period(output logic [3:0] hi, output logic [3:0] lo);
		level(1'b1, 14, hi);
		level(1'b0, 14, lo);
	endtask : period

	// counts cycles with every output off after a pin change
	task gap(input logic v, output int n);
		@(posedge clk);
		pwm <= v;
		n = 0;
		repeat (20) begin
			@(negedge clk);
			if (drive.out === 4'h0) n++;
		end
	endtask : gap

	task results;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		results();
	end

	initial begin
		mismatches = 0;
		checked = 0;
		rst = 1'b1;
		pwm = 1'b0;
		sd = 1'b0;
		pol = 4'h0;
		req = '0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, `OFF_CTRL0, 8'h00, d);
		chk("ctrl0 reset", d, 32'h00000000);
		bus(1'b0, 8'h44, 8'h00, d);
		chk("unmapped read", d, 32'h00000000);
		wr(`OFF_RSRC, 8'h01);
		wr(`OFF_RSENSE, 8'h01);
		wr(`OFF_FSRC, 8'h01);
		wr(`OFF_FSENSE, 8'h01);
		wr(`OFF_STEER, 8'h0F);
		// enabled, system clock as module clock so one tick per cycle
		wr(`OFF_CTRL0, 8'h90);
		period(h, l);
		chk("steered hi", h, 32'hF);
		chk("steered lo", l, 32'h0);
		level(1'b1, 14, h);
		wr(`OFF_STEER, 8'h01);
		level(1'b1, 2, h);
		chk("steer next cycle", h, 32'h1);
		level(1'b0, 14, l);
		wr(`OFF_CTRL0, 8'h92);
		period(h, l);
		chk("fwd hi", h, 32'h9);
		chk("fwd lo", l, 32'h1);
		wr(`OFF_CTRL0, 8'h93);
		period(h, l);
		chk("rev hi", h, 32'h6);
		chk("rev lo", l, 32'h4);
		wr(`OFF_STEER, 8'h0F);
		wr(`OFF_CTRL0, 8'h94);
		period(h, l);
		chk("half hi", h, 32'h5);
		chk("half lo", l, 32'hA);
		wr(`OFF_CTRL0, 8'h95);
		period(h, l);
		period(h2, l);
		chk("push swap", h ^ h2, 32'hF);
		chk("push pair", 32'((h == 4'h5) || (h == 4'hA)), 32'h1);
		chk("push lo", l, 32'h0);
		// synchronous steering waits for the next rise, static data does not
		wr(`OFF_CTRL0, 8'h91);
		level(1'b1, 14, h);
		wr(`OFF_STEER, 8'h01);
		level(1'b1, 2, h);
		chk("sync steer held", h, 32'hF);
		level(1'b0, 14, l);
		level(1'b1, 14, h);
		chk("sync steer applied", h, 32'h1);
		level(1'b0, 14, l);
		wr(`OFF_STEER, 8'hA0);
		level(1'b0, 2, l);
		chk("static data", l, 32'hA);
		// steering all four outputs on is legal, so shoot-through is counted from here
		ov0 = overlaps;
		// half-bridge dead-band of four ticks on each edge
		wr(`OFF_STEER, 8'h0F);
		wr(`OFF_RDB, 8'h04);
		wr(`OFF_FDB, 8'h04);
		wr(`OFF_CTRL0, 8'h94);
		gap(1'b1, g);
		chk("rise deadband", 32'((g >= 4) && (g <= 5)), 32'h1);
		gap(1'b0, g);
		chk("fall deadband", 32'((g >= 4) && (g <= 5)), 32'h1);
		wr(`OFF_RDB, 8'h00);
		wr(`OFF_FDB, 8'h00);
		// two instruction-clock ticks of rising phase delay keep the complement on
		wr(`OFF_RPH, 8'h02);
		wr(`OFF_CTRL0, 8'h8C);
		level(1'b1, 8, h);
		chk("phase early", h, 32'hA);
		level(1'b1, 8, h);
		chk("phase done", h, 32'h5);
		level(1'b0, 12, l);
		chk("phase fall", l, 32'hA);
		// a fall inside the falling blanking time is ignored
		wr(`OFF_RPH, 8'h00);
		wr(`OFF_FBK, 8'h14);
		wr(`OFF_CTRL0, 8'h94);
		level(1'b1, 3, h);
		level(1'b0, 10, l);
		chk("fall blanked", l, 32'h5);
		level(1'b1, 20, h);
		level(1'b0, 10, l);
		chk("fall after blank", l, 32'hA);
		wr(`OFF_FBK, 8'h00);
		wr(`OFF_CTRL1, 8'h0F);
		pol <= 4'hF;
		level(1'b0, 6, l);
		chk("polarity", l, 32'h5);
		wr(`OFF_CTRL1, 8'h00);
		pol <= 4'h0;
		// override a inactive, b high-z, c low, d high
		wr(`OFF_OVR, 8'hE4);
		wr(`OFF_SDSRC, 8'h01);
		@(posedge clk);
		sd <= 1'b1;
		level(1'b1, 10, h);
		chk("shutdown oe", drive.oe, 32'hD);
		chk("shutdown levels", {h[3:2], h[0]}, 32'h4);
		bus(1'b0, `OFF_STATUS, 8'h00, d);
		chk("shutdown flag", d[7], 32'h1);
		level(1'b0, 4, l);
		@(posedge clk);
		sd <= 1'b0;
		repeat (6) @(posedge clk);
		wr(`OFF_SDCTRL, 8'h01);
		bus(1'b0, `OFF_STATUS, 8'h00, d);
		chk("shutdown cleared", d[7], 32'h0);
		wr(`OFF_CTRL0, 8'h14);
		level(1'b1, 10, h);
		chk("disabled", h, 32'hA);
		level(1'b0, 4, l);
		chk("shoot-through", overlaps - ov0, 32'h0);
		results();
	end
endmodule : tb_top
`default_nettype wire
